// ---- dv/rxs_client_model.sv ----
module rxs_client_model (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // client stream
    input wire logic [7:0] dout_d_in,
    input wire logic dout_c_in,
    input wire logic dout_valid_in,
    input wire logic dout_eop_in,
    // per-frame status
    input wire logic fcs_error_in,
    input wire logic fcs_valid_in,
    input wire logic [2:0] status_in,
    input wire logic [5:0] error_in,
    // frame report
    output logic done_out,
    output logic [25:0] rec_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_q, sum_q, len_q, tot_q;
    logic [2:0] st_q;
    logic [5:0] er_q;
    logic fcs_q;

    always @(posedge core_clk_in) begin
        done_out <= 1'b0;
        if (rst_in) begin
            {cnt_q, sum_q, len_q, tot_q, st_q, er_q, fcs_q} <= '0;
        end else begin
            if (dout_valid_in) begin
                cnt_q <= dout_c_in ? 8'h00 : cnt_q + 8'h01;
                sum_q <= dout_c_in ? 8'h00 : sum_q + dout_d_in;
            end
            // status is only trusted in the eop cycle
            if (dout_eop_in) begin
                len_q <= cnt_q + 8'h01;
                tot_q <= sum_q + dout_d_in;
                st_q <= status_in;
                er_q <= error_in;
                cnt_q <= 8'h00;
                sum_q <= 8'h00;
            end
            // latched fields survive a late fcs report
            if (fcs_valid_in) begin
                done_out <= 1'b1;
                fcs_q <= fcs_error_in;
            end
        end
    end
    assign rec_out = {len_q, tot_q, st_q, er_q, fcs_q};
endmodule // rxs_client_model

// ---- dv/rxs_rx_status_asserts.sv ----
`include "rxs_defs.vh"

module rxs_rx_status_asserts #(
    parameter EOP_ALIGN = 1,
    parameter PREAMBLE_PASS = 0
) (
    // clock and reset
    input wire core_clk_in,
    input wire rst_in,
    // client stream
    input wire rx_mac_clk_out,
    input wire [7:0] dout_d_out,
    input wire dout_c_out,
    input wire dout_valid_out,
    input wire dout_eop_out,
    // per-frame status
    input wire rx_fcs_error_out,
    input wire rx_fcs_valid_out,
    input wire [2:0] rx_status_out,
    input wire [5:0] rx_error_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // flag-0 bytes since the last start byte; only meaningful with pass-through
    logic [7:0] cnt_q;
    wire [7:0] len_w = cnt_q - 8'h06;

    always @(posedge core_clk_in) begin
        if (rst_in) cnt_q <= 8'h00;
        else if (dout_valid_out) cnt_q <= dout_c_out ? 8'h00 : cnt_q + 8'h01;
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    property p_fcs_at_eop;
        (EOP_ALIGN != 0) && dout_eop_out |-> rx_fcs_valid_out;
    endproperty
    a_fcs_at_eop: assert property (p_fcs_at_eop) else $error("fcs valid missing at eop");
    property p_fcs_src;
        rx_fcs_valid_out |-> ((EOP_ALIGN != 0) ? dout_eop_out : $past(dout_eop_out, 3));
    endproperty
    a_fcs_src: assert property (p_fcs_src) else $error("fcs valid without its eop");
    property p_status_eop;
        !dout_eop_out |-> rx_status_out == 3'h0;
    endproperty
    a_status_eop: assert property (p_status_eop) else $error("status outside eop");
    property p_status_kind;
        dout_eop_out |-> $onehot0(rx_status_out);
    endproperty
    a_status_kind: assert property (p_status_kind) else $error("two frame kinds at once");
    property p_crc_bit;
        (EOP_ALIGN != 0) && dout_eop_out |-> rx_error_out[1] == rx_fcs_error_out;
    endproperty
    a_crc_bit: assert property (p_crc_bit) else $error("crc bit differs from fcs flag");
    property p_runt;
        (PREAMBLE_PASS != 0) && dout_eop_out |-> rx_error_out[2] == (len_w >= 8'h09 && len_w <= 8'h3F);
    endproperty
    a_runt: assert property (p_runt) else $error("runt bit wrong for length");
    property p_runt_fcs;
        (EOP_ALIGN != 0) && dout_eop_out && rx_error_out[2] |-> rx_fcs_error_out && rx_fcs_valid_out;
    endproperty
    a_runt_fcs: assert property (p_runt_fcs) else $error("runt without fcs error");
    property p_eop_byte;
        dout_eop_out |-> dout_valid_out && !dout_c_out;
    endproperty
    a_eop_byte: assert property (p_eop_byte) else $error("eop byte not valid payload");
    property p_pre_start;
        dout_valid_out && dout_c_out |-> (PREAMBLE_PASS != 0) && dout_d_out == `RXS_CH_START;
    endproperty
    a_pre_start: assert property (p_pre_start) else $error("control flag on non start byte");
    property p_pre_len;
        (PREAMBLE_PASS != 0) && dout_eop_out |-> cnt_q >= 8'h07;
    endproperty
    a_pre_len: assert property (p_pre_len) else $error("preamble bytes missing");
    // combinational copy still shows the low phase in the preponed sample
    property p_clk_out;
        rx_mac_clk_out == 1'b0;
    endproperty
    a_clk_out: assert property (p_clk_out) else $error("mac clock not following core clock");

    c_fcs_err: cover property (dout_eop_out && rx_fcs_error_out);
    c_ctrl: cover property (dout_eop_out && rx_status_out != 3'h0);
    c_runt: cover property (dout_eop_out && rx_error_out[2]);
endmodule // rxs_rx_status_asserts

bind rxs_rx_status rxs_rx_status_asserts #(.EOP_ALIGN(EOP_ALIGN), .PREAMBLE_PASS(PREAMBLE_PASS))
    i_rxs_rx_status_asserts (.core_clk_in, .rst_in, .rx_mac_clk_out, .dout_d_out, .dout_c_out, .dout_valid_out,
    .dout_eop_out, .rx_fcs_error_out, .rx_fcs_valid_out, .rx_status_out, .rx_error_out);

// ---- dv/tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic lane_valid_in = 1'b0;
    logic [7:0] lane_data_in = 8'h00;
    logic lane_ctrl_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    wire [31:0] reg_rdata_out;
    wire [7:0] dout_d_out;
    wire dout_c_out, dout_valid_out, dout_eop_out, rx_fcs_error_out, rx_fcs_valid_out, irq_out, done;
    wire [2:0] rx_status_out;
    wire [5:0] rx_error_out;
    wire [25:0] rec;
    int miscompares = 0;
    int checked = 0;
    logic [31:0] rs = 32'hD9798095;
    logic [31:0] rq[$];
    logic [25:0] fq[$];
    logic rd_p = 1'b0;
    logic [7:0] fb[0:127];
    logic [1:0] md = 2'h0;
    logic fw = 1'b0;
    logic ef = 1'b0;
    int nf = 0;
    wire fv2, fe2;

    always #25 core_clk_in = ~core_clk_in;

    rxs_rx_status #(.EOP_ALIGN(1), .PREAMBLE_PASS(1)) i_rxs_rx_status (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .lane_valid_in(lane_valid_in), .lane_data_in(lane_data_in), .lane_ctrl_in(lane_ctrl_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .rx_mac_clk_out(), .dout_d_out(dout_d_out), .dout_c_out(dout_c_out),
        .dout_valid_out(dout_valid_out), .dout_eop_out(dout_eop_out), .rx_fcs_error_out(rx_fcs_error_out),
        .rx_fcs_valid_out(rx_fcs_valid_out), .rx_status_out(rx_status_out), .rx_error_out(rx_error_out),
        .irq_out(irq_out));

    rxs_client_model i_rxs_client_model (.core_clk_in(core_clk_in), .rst_in(rst_in), .dout_d_in(dout_d_out),
        .dout_c_in(dout_c_out), .dout_valid_in(dout_valid_out), .dout_eop_in(dout_eop_out),
        .fcs_error_in(rx_fcs_error_out), .fcs_valid_in(rx_fcs_valid_out), .status_in(rx_status_out),
        .error_in(rx_error_out), .done_out(done), .rec_out(rec));

    // second build with the fcs report lagging eop; same byte stream and registers
    rxs_rx_status #(.EOP_ALIGN(0), .PREAMBLE_PASS(0)) i_rxs_rx_status_lag (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .lane_valid_in(lane_valid_in), .lane_data_in(lane_data_in), .lane_ctrl_in(lane_ctrl_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(), .rx_mac_clk_out(), .dout_d_out(), .dout_c_out(), .dout_valid_out(), .dout_eop_out(),
        .rx_fcs_error_out(fe2), .rx_fcs_valid_out(fv2), .rx_status_out(), .rx_error_out(), .irq_out());

    function logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    function logic [31:0] crc_b(input logic [31:0] c, input logic [7:0] d);
        c = c ^ {24'h0, d};
        for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
        return c;
    endfunction

    task check(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task wrap_up();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task done_test(input string t);
        $display("test %0s done", t);
    endtask

    task reg_op(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        reg_wr_in <= w;
        reg_rd_in <= !w;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        if (!w) rq.push_back(d);
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
    endtask

    task irq_is(input logic e);
        @(negedge core_clk_in);
        check({31'h0, irq_out}, {31'h0, e});
    endtask

    // random idle gaps stretch the frame on the client side too
    task send(input logic c, input logic [7:0] d);
        if (rnd() % 5 == 0) begin
            @(posedge core_clk_in);
            lane_valid_in <= 1'b0;
        end
        @(posedge core_clk_in);
        lane_valid_in <= 1'b1;
        lane_ctrl_in <= c;
        lane_data_in <= d;
    endtask

    task frame(input int n, input int k, input logic bad);
        logic [31:0] c;
        logic [7:0] s;
        int L;
        c = 32'hFFFFFFFF;
        s = 8'hD3;
        L = n + 4;
        for (int i = 0; i < n; i++) fb[i] = 8'(rnd());
        if (n > 15) begin
            fb[12] = k ? 8'h88 : 8'h00;
            fb[13] = 8'h08;
            fb[14] = {7'h0, k == 2};
            fb[15] = k == 3 ? 8'h02 : 8'h01;
        end
        for (int i = 0; i < n; i++) c = crc_b(c, fb[i]);
        c = ~c ^ {31'h0, bad};
        for (int i = 0; i < 4; i++) fb[n + i] = c[8 * i +: 8];
        for (int i = 0; i < L; i++) s = s + fb[i];
        fq.push_back({8'(L + 7), s, k == 3, k == 2 && !(md == 2'h2 && !fw), k == 1 && !(md == 2'h1 && !fw),
            3'h0, L > 8 && L < 64, bad || (L > 8 && L < 64), L <= 8, bad || (L > 8 && L < 64)});
        send(1'b1, 8'hFB);
        for (int i = 0; i < 7; i++) send(1'b0, i == 6 ? 8'hD5 : 8'h55);
        for (int i = 0; i < L; i++) send(1'b0, fb[i]);
        send(1'b1, 8'hFD);
        @(posedge core_clk_in);
        lane_valid_in <= 1'b0;
        repeat (6) @(posedge core_clk_in);
    endtask

    always @(negedge core_clk_in) begin
        if (rd_p) check(reg_rdata_out, rq.pop_front());
        rd_p = reg_rd_in;
        if (done) begin
            ef = fq[0][0];
            nf++;
            check({6'h0, rec}, fq.pop_front());
        end
        // the lagging build reports the same verdict a few cycles later
        if (fv2) begin
            nf--;
            check({31'h0, fe2}, {31'h0, ef});
        end
    end

    initial begin
        repeat (3) @(posedge core_clk_in);
        rst_in <= 1'b0;
        reg_op(1'b1, 8'h18, 32'h5);
        for (int a = 0; a < 28; a += 4) reg_op(1'b0, 8'(a), 32'h0);
        done_test("regs");
        frame(5, 0, 1'b0);
        reg_op(1'b0, 8'h04, 32'h3);
        irq_is(1'b0);
        reg_op(1'b1, 8'h08, 32'h2);
        irq_is(1'b1);
        reg_op(1'b1, 8'h04, 32'h2);
        irq_is(1'b0);
        reg_op(1'b0, 8'h04, 32'h1);
        reg_op(1'b1, 8'h04, 32'h1F);
        done_test("runt irq");
        frame(4, 0, 1'b0);
        reg_op(1'b0, 8'h04, 32'h4);
        frame(4, 0, 1'b1);
        reg_op(1'b1, 8'h04, 32'h1F);
        done_test("short");
        for (int m = 0; m < 3; m++) begin
            for (int f = 0; f < 2; f++) begin
                md = 2'(m);
                fw = 1'(f);
                reg_op(1'b1, 8'h00, {29'h0, md, fw});
                reg_op(1'b0, 8'h00, {29'h0, md, fw});
                for (int k = 1; k < 4; k++) frame(60, k, 1'b0);
            end
        end
        done_test("control");
        for (int i = 0; i < 8; i++) frame(60 + rnd() % 40, 0, rnd() % 4 == 0);
        done_test("random");
        repeat (10) @(posedge core_clk_in);
        check(fq.size() + rq.size() + nf, 0);
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge core_clk_in);
        miscompares++;
        wrap_up();
    end
endmodule // tb

// ---- pkg/rxs_defs.vh ----
`ifndef RXS_DEFS_VH
`define RXS_DEFS_VH

// register byte offsets
`define RXS_OFF_CTRL 8'h00
`define RXS_OFF_STATUS 8'h04
`define RXS_OFF_MASK 8'h08
`define RXS_OFF_FRAMES 8'h0C
`define RXS_OFF_FCS_ERRS 8'h10
`define RXS_OFF_LAST_LEN 8'h14

// control register fields
`define RXS_CTRL_FWD_BIT 0
`define RXS_CTRL_MODE_LO 1
`define RXS_CTRL_MODE_HI 2
`define RXS_CTRL_RESET 3'h0

// flow control mode encodings
`define RXS_FC_NONE 2'h0
`define RXS_FC_STD 2'h1
`define RXS_FC_PFC 2'h2

// event status bits, mask has the same layout
`define RXS_EV_FCS 0
`define RXS_EV_RUNT 1
`define RXS_EV_DECODE 2
`define RXS_EV_CTRL 3
`define RXS_EV_MALFORMED 4
`define RXS_EV_WIDTH 5
`define RXS_EV_RESET 5'h00
`define RXS_MASK_RESET 5'h00

// error vector bits
`define RXS_ERR_MALFORMED 0
`define RXS_ERR_CRC 1
`define RXS_ERR_UNDERSIZE 2

// line coding
`define RXS_CH_START 8'hFB
`define RXS_CH_TERM 8'hFD
`define RXS_PRE_BYTES 3'h7

// frame sizes
`define RXS_RUNT_MIN 16'h0009
`define RXS_RUNT_MAX 16'h003F
`define RXS_DECODE_MAX 16'h0008

// control frame identification
`define RXS_TYPE_MAC_CTRL 16'h8808
`define RXS_OP_STD 16'h0001
`define RXS_OP_PFC 16'h0101
`define RXS_TYPE_IDX 16'h000C
`define RXS_OP_END_IDX 16'h000F

// crc-32
`define RXS_CRC_INIT 32'hFFFFFFFF
`define RXS_CRC_POLY 32'hEDB88320
`define RXS_CRC_RESIDUE 32'hDEBB20E3

// fcs report lag when eop alignment is off
`define RXS_FCS_LAG 3

// nominal rx mac clock in khz
`define RXS_RXMAC_CLK_KHZ 390625

`endif

// ---- rtl/rxs_crc32.v ----
`include "rxs_defs.vh"

module rxs_crc32 (
    // clock and reset
    input wire core_clk_in,
    input wire rst_in,
    // byte feed
    input wire init_in,
    input wire en_in,
    input wire [7:0] data_in,
    // running remainder
    output wire [31:0] crc_out
);

    reg [31:0] crc_q;
    reg [31:0] crc_d;

    function [31:0] crc_byte;
        input [31:0] crc;
        input [7:0] data;
        integer i;
        reg [31:0] c;
        begin
            c = crc ^ {24'h000000, data};
            for (i = 0; i < 8; i = i + 1) begin
                c = c[0] ? ((c >> 1) ^ `RXS_CRC_POLY) : (c >> 1);
            end
            crc_byte = c;
        end
    endfunction

    always @* begin
        crc_d = crc_q;
        if (init_in) begin
            crc_d = `RXS_CRC_INIT;
        end else if (en_in) begin
            crc_d = crc_byte(crc_q, data_in);
        end
    end

    always @(posedge core_clk_in) begin
        if (rst_in) begin
            crc_q <= `RXS_CRC_INIT;
        end else begin
            crc_q <= crc_d;
        end
    end

    assign crc_out = crc_q;

endmodule // rxs_crc32

// ---- rtl/rxs_lag_pipe.v ----
`include "rxs_defs.vh"

module rxs_lag_pipe (
    // clock and reset
    input wire core_clk_in,
    input wire rst_in,
    // input report
    input wire valid_in,
    input wire bit_in,
    // delayed report
    output wire valid_out,
    output wire bit_out
);

    localparam DEPTH = `RXS_FCS_LAG;

    reg [DEPTH-1:0] v_q;
    reg [DEPTH-1:0] b_q;

    always @(posedge core_clk_in) begin
        if (rst_in) begin
            v_q[0] <= 1'b0;
            b_q[0] <= 1'b0;
        end else begin
            v_q[0] <= valid_in;
            b_q[0] <= bit_in;
        end
    end

    genvar g;
    generate
        for (g = 1; g < DEPTH; g = g + 1) begin : stage
            always @(posedge core_clk_in) begin
                if (rst_in) begin
                    v_q[g] <= 1'b0;
                    b_q[g] <= 1'b0;
                end else begin
                    v_q[g] <= v_q[g-1];
                    b_q[g] <= b_q[g-1];
                end
            end
        end
    endgenerate

    assign valid_out = v_q[DEPTH-1];
    assign bit_out = b_q[DEPTH-1];

endmodule // rxs_lag_pipe

// ---- rtl/rxs_rx_status.v ----
// The plain strobed port and the register offsets are this design's own decisions.
`include "rxs_defs.vh"

// Behaviour
// - raise fcs error when the latest eop belongs to a frame with bad crc-32.
// - with eop alignment on, fcs error appears in the eop cycle.
// - with eop alignment off, fcs error may follow eop by some cycles.
// - runt frames always raise the fcs error flag.
// - packets of eight bytes or fewer are decode errors, never runts.
// - fcs valid marks each cycle where fcs error is meaningful.
// - three-bit control frame type is shown only in eop cycles.
// - bit 0 marks standard pause; held 0 in standard mode without forwarding.
// - bit 1 marks priority pause; held 0 in priority mode without forwarding.
// - bit 2 marks any other mac control frame.
// - output valid high while output data holds valid contents; may drop.
// - rx mac clock driven out and all client outputs timed on it.
// - payload bytes leave with control flag 0 and the packet data.
// - pass-through preamble: start byte flag 1, preamble and sfd flag 0.
// - with alignment on, error vector crc bit equals the fcs error flag.
module rxs_rx_status #(
    parameter EOP_ALIGN = 1,
    parameter PREAMBLE_PASS = 0
) (
    // clock and reset
    input wire core_clk_in,
    input wire rst_in,
    // decoded line bytes
    input wire lane_valid_in,
    input wire [7:0] lane_data_in,
    input wire lane_ctrl_in,
    // register port
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output wire [31:0] reg_rdata_out,
    // client stream
    output wire rx_mac_clk_out,
    output wire [7:0] dout_d_out,
    output wire dout_c_out,
    output wire dout_valid_out,
    output wire dout_eop_out,
    // per-frame status
    output wire rx_fcs_error_out,
    output wire rx_fcs_valid_out,
    output wire [2:0] rx_status_out,
    output wire [5:0] rx_error_out,
    // interrupt
    output wire irq_out
);

    localparam ST_IDLE = 2'h0;
    localparam ST_PRE = 2'h1;
    localparam ST_DATA = 2'h2;

    function is_ctrl_char;
        input [7:0] data;
        input ctrl;
        input [7:0] code;
        begin
            is_ctrl_char = ctrl && (data == code);
        end
    endfunction

    reg [1:0] state_q;
    reg [2:0] pre_cnt_q;
    reg [15:0] len_q;
    reg [15:0] type_q;
    reg [15:0] op_q;
    reg [7:0] hold_d_q;
    reg hold_c_q;
    reg hold_v_q;
    reg [7:0] dout_d_q;
    reg dout_c_q;
    reg dout_valid_q;
    reg dout_eop_q;
    reg fcs_err_q;
    reg fcs_valid_q;
    reg [2:0] status_q;
    reg [5:0] error_q;
    reg [2:0] ctrl_q;
    reg [`RXS_EV_WIDTH-1:0] ev_q;
    reg [`RXS_EV_WIDTH-1:0] mask_q;
    reg [15:0] frames_q;
    reg [15:0] fcs_cnt_q;
    reg [15:0] last_len_q;
    reg [31:0] rdata_q;

    wire is_start = is_ctrl_char(lane_data_in, lane_ctrl_in, `RXS_CH_START);
    wire is_term = is_ctrl_char(lane_data_in, lane_ctrl_in, `RXS_CH_TERM);
    wire in_data = lane_valid_in && (state_q == ST_DATA);
    wire data_byte = in_data && !lane_ctrl_in;
    wire frame_end = in_data && lane_ctrl_in;
    wire malformed = frame_end && !is_term;
    wire pre_abort = lane_valid_in && (state_q == ST_PRE) && lane_ctrl_in;
    wire eop_fire = frame_end && hold_v_q;
    wire [31:0] crc;
    wire [1:0] fc_mode = ctrl_q[`RXS_CTRL_MODE_HI:`RXS_CTRL_MODE_LO];
    wire fwd_ctrl = ctrl_q[`RXS_CTRL_FWD_BIT];

    // size checks on the finished frame
    wire decode_err = frame_end && (len_q <= `RXS_DECODE_MAX);
    wire runt = frame_end && (len_q >= `RXS_RUNT_MIN) && (len_q <= `RXS_RUNT_MAX);
    wire crc_bad = crc != `RXS_CRC_RESIDUE;
    wire fcs_bad = crc_bad || runt;

    // control frame type, checked once type and opcode are complete
    wire is_mac_ctrl = (len_q > `RXS_OP_END_IDX) && (type_q == `RXS_TYPE_MAC_CTRL);
    wire std_frame = is_mac_ctrl && (op_q == `RXS_OP_STD);
    wire pfc_frame = is_mac_ctrl && (op_q == `RXS_OP_PFC);
    wire [2:0] ctrl_kind;
    assign ctrl_kind[0] = std_frame && !(fc_mode == `RXS_FC_STD && !fwd_ctrl);
    assign ctrl_kind[1] = pfc_frame && !(fc_mode == `RXS_FC_PFC && !fwd_ctrl);
    assign ctrl_kind[2] = is_mac_ctrl && !std_frame && !pfc_frame;

    // crc covers every byte after the sfd, fcs included
    rxs_crc32 u_crc (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .init_in(lane_valid_in && is_start),
        .en_in(data_byte),
        .data_in(lane_data_in),
        .crc_out(crc)
    );

    // frame tracking
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            pre_cnt_q <= 3'h0;
            len_q <= 16'h0000;
            type_q <= 16'h0000;
            op_q <= 16'h0000;
        end else if (lane_valid_in) begin
            case (state_q)
                ST_IDLE: begin
                    if (is_start) begin
                        state_q <= ST_PRE;
                        pre_cnt_q <= 3'h0;
                        len_q <= 16'h0000;
                    end
                end
                ST_PRE: begin
                    if (lane_ctrl_in) begin
                        state_q <= ST_IDLE;
                    end else if (pre_cnt_q == `RXS_PRE_BYTES - 3'h1) begin
                        state_q <= ST_DATA;
                    end else begin
                        pre_cnt_q <= pre_cnt_q + 3'h1;
                    end
                end
                ST_DATA: begin
                    if (lane_ctrl_in) begin
                        state_q <= ST_IDLE;
                    end else begin
                        // saturate so jumbo frames never wrap into runt range
                        if (len_q != 16'hFFFF) begin
                            len_q <= len_q + 16'h0001;
                        end
                        if (len_q == `RXS_TYPE_IDX || len_q == `RXS_TYPE_IDX + 16'h0001) begin
                            type_q <= {type_q[7:0], lane_data_in};
                        end
                        if (len_q == `RXS_OP_END_IDX - 16'h0001 || len_q == `RXS_OP_END_IDX) begin
                            op_q <= {op_q[7:0], lane_data_in};
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // one byte of hold lets the last payload byte carry eop
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            hold_d_q <= 8'h00;
            hold_c_q <= 1'b0;
            hold_v_q <= 1'b0;
            dout_d_q <= 8'h00;
            dout_c_q <= 1'b0;
            dout_valid_q <= 1'b0;
            dout_eop_q <= 1'b0;
        end else begin
            dout_valid_q <= 1'b0;
            dout_eop_q <= 1'b0;
            if (frame_end || pre_abort) begin
                hold_v_q <= 1'b0;
                if (hold_v_q && frame_end) begin
                    dout_d_q <= hold_d_q;
                    dout_c_q <= hold_c_q;
                    dout_valid_q <= 1'b1;
                    dout_eop_q <= 1'b1;
                end
            end else if (lane_valid_in && (data_byte ||
                         (PREAMBLE_PASS != 0 && (state_q == ST_PRE || (state_q == ST_IDLE && is_start))))) begin
                // preamble bytes only enter the stream in pass-through builds
                hold_d_q <= lane_data_in;
                hold_c_q <= (state_q == ST_IDLE) ? 1'b1 : 1'b0;
                hold_v_q <= 1'b1;
                if (hold_v_q) begin
                    dout_d_q <= hold_d_q;
                    dout_c_q <= hold_c_q;
                    dout_valid_q <= 1'b1;
                end
            end
        end
    end

    // eop-cycle status
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            status_q <= 3'h0;
            error_q <= 6'h00;
        end else begin
            status_q <= 3'h0;
            error_q <= 6'h00;
            if (eop_fire) begin
                status_q <= ctrl_kind;
                error_q[`RXS_ERR_MALFORMED] <= malformed || decode_err;
                error_q[`RXS_ERR_CRC] <= fcs_bad;
                error_q[`RXS_ERR_UNDERSIZE] <= runt;
            end
        end
    end

    // fcs report, aligned or lagging as built
    wire lag_valid;
    wire lag_bit;
    generate
        if (EOP_ALIGN != 0) begin : g_align
            assign lag_valid = eop_fire;
            assign lag_bit = fcs_bad;
        end else begin : g_lag
            rxs_lag_pipe u_lag (
                .core_clk_in(core_clk_in),
                .rst_in(rst_in),
                .valid_in(eop_fire),
                .bit_in(fcs_bad),
                .valid_out(lag_valid),
                .bit_out(lag_bit)
            );
        end
    endgenerate

    always @(posedge core_clk_in) begin
        if (rst_in) begin
            fcs_err_q <= 1'b0;
            fcs_valid_q <= 1'b0;
        end else begin
            fcs_valid_q <= lag_valid;
            if (lag_valid) begin
                fcs_err_q <= lag_bit;
            end
        end
    end

    // events, counters and register port
    wire [`RXS_EV_WIDTH-1:0] ev_set;
    assign ev_set[`RXS_EV_FCS] = eop_fire && fcs_bad;
    assign ev_set[`RXS_EV_RUNT] = runt;
    assign ev_set[`RXS_EV_DECODE] = decode_err || pre_abort;
    assign ev_set[`RXS_EV_CTRL] = eop_fire && is_mac_ctrl;
    assign ev_set[`RXS_EV_MALFORMED] = malformed;

    wire wr_status = reg_wr_in && reg_addr_in == `RXS_OFF_STATUS;

    always @(posedge core_clk_in) begin
        if (rst_in) begin
            ctrl_q <= `RXS_CTRL_RESET;
            mask_q <= `RXS_MASK_RESET;
            ev_q <= `RXS_EV_RESET;
            frames_q <= 16'h0000;
            fcs_cnt_q <= 16'h0000;
            last_len_q <= 16'h0000;
        end else begin
            if (reg_wr_in && reg_addr_in == `RXS_OFF_CTRL) begin
                ctrl_q <= reg_wdata_in[2:0];
            end
            if (reg_wr_in && reg_addr_in == `RXS_OFF_MASK) begin
                mask_q <= reg_wdata_in[`RXS_EV_WIDTH-1:0];
            end
            // a new event beats a same-cycle write-one clear
            ev_q <= (ev_q & ~(wr_status ? reg_wdata_in[`RXS_EV_WIDTH-1:0] : `RXS_EV_RESET)) | ev_set;
            if (eop_fire) begin
                frames_q <= frames_q + 16'h0001;
                last_len_q <= len_q;
                if (fcs_bad) begin
                    fcs_cnt_q <= fcs_cnt_q + 16'h0001;
                end
            end
        end
    end

    always @(posedge core_clk_in) begin
        if (rst_in) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= 32'h00000000;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `RXS_OFF_CTRL: rdata_q <= {29'h00000000, ctrl_q};
                    `RXS_OFF_STATUS: rdata_q <= {27'h0000000, ev_q};
                    `RXS_OFF_MASK: rdata_q <= {27'h0000000, mask_q};
                    `RXS_OFF_FRAMES: rdata_q <= {16'h0000, frames_q};
                    `RXS_OFF_FCS_ERRS: rdata_q <= {16'h0000, fcs_cnt_q};
                    `RXS_OFF_LAST_LEN: rdata_q <= {16'h0000, last_len_q};
                    default: rdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    // the core clock stands in for the recovered clock
    assign rx_mac_clk_out = core_clk_in;
    assign dout_d_out = dout_d_q;
    assign dout_c_out = dout_c_q;
    assign dout_valid_out = dout_valid_q;
    assign dout_eop_out = dout_eop_q;
    assign rx_fcs_error_out = fcs_err_q;
    assign rx_fcs_valid_out = fcs_valid_q;
    assign rx_status_out = status_q;
    assign rx_error_out = error_q;
    assign reg_rdata_out = rdata_q;
    assign irq_out = |(ev_q & mask_q);

endmodule // rxs_rx_status
